/* tmr_pkg.sv */
package tmr_pkg;

   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL_A = 8'h80;
   localparam logic [7:0] ADDR_CTRL_B = 8'h81;
   localparam logic [7:0] ADDR_CTRL_C = 8'h82;
   localparam logic [7:0] ADDR_FLAGS  = 8'h83;
   localparam logic [7:0] ADDR_CNT_L  = 8'h84;
   localparam logic [7:0] ADDR_CNT_H  = 8'h85;
   localparam logic [7:0] ADDR_CAP_L  = 8'h86;
   localparam logic [7:0] ADDR_CAP_H  = 8'h87;
   localparam logic [7:0] ADDR_CMPA_L = 8'h88;
   localparam logic [7:0] ADDR_CMPA_H = 8'h89;
   localparam logic [7:0] ADDR_CMPB_L = 8'h8A;
   localparam logic [7:0] ADDR_CMPB_H = 8'h8B;

   // Control A fields
   localparam int COMA_MSB = 7;
   localparam int COMA_LSB = 6;
   localparam int COMB_MSB = 5;
   localparam int COMB_LSB = 4;
   localparam int WAVE_LO_MSB = 1;
   // Control B fields
   localparam int NOISE_BIT = 7;
   localparam int EDGE_BIT  = 6;
   localparam int WAVE_HI_MSB = 4;
   localparam int WAVE_HI_LSB = 3;
   localparam int CSEL_MSB  = 2;
   localparam logic [7:0] CTRL_B_MASK = 8'hDF;
   // Control C fields
   localparam int FORCE_A_BIT = 7;
   localparam int FORCE_B_BIT = 6;
   // Flag register fields
   localparam int FLAG_CAP  = 5;
   localparam int FLAG_CMPB = 2;
   localparam int FLAG_CMPA = 1;
   localparam int FLAG_OVF  = 0;

   // Reset values
   localparam logic [7:0]  CTRL_RST = 8'h00;
   localparam logic [15:0] WORD_RST = 16'h0000;

   // Clock select codes
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_D64  = 3'h3;
   localparam logic [2:0] CS_D256 = 3'h4;
   localparam logic [2:0] CS_D1K  = 3'h5;
   localparam logic [2:0] CS_EXTF = 3'h6;
   localparam logic [2:0] CS_EXTR = 3'h7;
   // Prescaler tap masks
   localparam logic [9:0] MASK_D8   = 10'h007;
   localparam logic [9:0] MASK_D64  = 10'h03F;
   localparam logic [9:0] MASK_D256 = 10'h0FF;
   localparam logic [9:0] MASK_D1K  = 10'h3FF;

   // Top values
   localparam logic [15:0] TOP_MAX = 16'hFFFF;
   localparam logic [15:0] TOP_8B  = 16'h00FF;
   localparam logic [15:0] TOP_9B  = 16'h01FF;
   localparam logic [15:0] TOP_10B = 16'h03FF;

   // Compare output mode codes, non-PWM
   localparam logic [1:0] COM_OFF    = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR  = 2'h2;
   localparam logic [1:0] COM_SET    = 2'h3;

   // Capture filter depth
   localparam int FILT_LEN = 4;

   // Register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tmr_bus_type;

   // Whole state of one timer unit
   typedef struct packed {
      logic [7:0]          ctrlA;
      logic [7:0]          ctrlB;
      logic [15:0]         cnt;
      logic [15:0]         cmpA;
      logic [15:0]         cmpB;
      logic [15:0]         cap;
      logic [7:0]          temp;
      logic [7:0]          rdata;
      logic [3:0]          flags;
      logic [2:0]          capSync;
      logic [2:0]          extSync;
      logic                capStable;
      logic                extStable;
      logic [FILT_LEN-1:0] capHist;
      logic                capFilt;
      logic                capPrev;
      logic                extPrev;
      logic [9:0]          pre;
      logic                block;
      logic                waveA;
      logic                waveB;
   } tmr_state_type;

endpackage : tmr_pkg

/* tmr_unit.sv */
// Contract
// - Filter changes after four equal samples
// - Filter adds four cycles capture delay
// - Edge select: zero falling, one rising
// - Capture copies counter, sets capture flag
// - Capture off when capture sets top
// - Mode bits four three join low bits
// - Clock select: stop, prescales, external edges
// - External pin counts even as output
// - Force only in non-PWM modes
// - Force applies compare action immediately
// - Force sets no flag, no clear
// - Force bits always read zero
// - Sixteen-bit access via high-byte latch
// - One latch shared by all four word registers
// - Counter write blocks next match
// - Compare every timer clock, drive output in non-PWM modes only
// - Capture copies counter to capture register, trigger from pin/comparator
// - Mode selects sequence and top
// - Non-PWM output mode decode
`timescale 1ns/1ps

module tmr_unit (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // Register bus
   input  wire tmr_pkg::tmr_bus_type bus,
   output wire logic [7:0]        rdata,
   // Pins
   input  wire logic              capturePin,
   input  wire logic              extCountPin,
   input  wire logic              compOut,
   input  wire logic              capFromComp,
   // Waveform outputs
   output wire logic              waveOutA,
   output wire logic              waveEnA,
   output wire logic              waveOutB,
   output wire logic              waveEnB,
   // Event flags
   output wire logic [3:0]        eventFlags
);

   tmr_pkg::tmr_state_type st_r;     // Registered state
   tmr_pkg::tmr_state_type st_nxt;   // Next state

   logic [3:0]  waveMode;            // Full waveform mode
   logic [2:0]  clkSel;              // Clock select field
   logic [1:0]  comA;                // Output mode, channel A
   logic [1:0]  comB;                // Output mode, channel B
   logic        nonPwm;              // Normal or clear-on-match
   logic        capIsTop;            // Capture register sets top
   logic        ctcA;                // Clear-on-match, top from A
   logic [15:0] top;                 // Current top value
   logic        tick;                // Timer clock enable
   logic        capLevel;            // Selected capture level
   logic        capEdge;             // Capture trigger
   logic        matchA;              // Compare match A on tick
   logic        matchB;              // Compare match B on tick
   logic        wrCnt;               // Counter low byte write
   logic        forceA;              // Forced strobe A
   logic        forceB;              // Forced strobe B
   logic [3:0]  flagSet;             // Hardware flag sets
   logic [3:0]  flagClr;             // Software flag clears

   // Apply the compare output action to a waveform bit
   function automatic logic waveAct(input logic [1:0] com,
                                    input logic       cur);
      logic res;
      res = cur;
      unique case (com)
         tmr_pkg::COM_OFF:    res = cur;
         tmr_pkg::COM_TOGGLE: res = ~cur;
         tmr_pkg::COM_CLEAR:  res = 1'b0;
         tmr_pkg::COM_SET:    res = 1'b1;
      endcase
      return res;
   endfunction : waveAct

   // Field decode of the control registers
   always_comb begin
      waveMode = {st_r.ctrlB[tmr_pkg::WAVE_HI_MSB:
                             tmr_pkg::WAVE_HI_LSB],
                  st_r.ctrlA[tmr_pkg::WAVE_LO_MSB:0]};
      clkSel = st_r.ctrlB[tmr_pkg::CSEL_MSB:0];
      comA   = st_r.ctrlA[tmr_pkg::COMA_MSB:tmr_pkg::COMA_LSB];
      comB   = st_r.ctrlA[tmr_pkg::COMB_MSB:tmr_pkg::COMB_LSB];
   end

   // Top source and mode class per waveform mode
   always_comb begin
      nonPwm   = 1'b0;
      capIsTop = 1'b0;
      ctcA     = 1'b0;
      top      = tmr_pkg::TOP_MAX;
      unique case (waveMode)
         4'h0: begin
            nonPwm = 1'b1;
         end
         4'h1, 4'h5: top = tmr_pkg::TOP_8B;
         4'h2, 4'h6: top = tmr_pkg::TOP_9B;
         4'h3, 4'h7: top = tmr_pkg::TOP_10B;
         4'h4: begin
            nonPwm = 1'b1;
            ctcA   = 1'b1;
            top    = st_r.cmpA;
         end
         4'h9, 4'hB, 4'hF: top = st_r.cmpA;
         4'hC: begin
            nonPwm   = 1'b1;
            capIsTop = 1'b1;
            top      = st_r.cap;
         end
         4'h8, 4'hA, 4'hE: begin
            capIsTop = 1'b1;
            top      = st_r.cap;
         end
         // Reserved code behaves as free running
         4'hD: top = tmr_pkg::TOP_MAX;
      endcase
   end

   // Timer clock enable from prescaler or external pin
   always_comb begin
      unique case (clkSel)
         tmr_pkg::CS_STOP: tick = 1'b0;
         tmr_pkg::CS_DIV1: tick = 1'b1;
         tmr_pkg::CS_DIV8:
            tick = &(st_r.pre | ~tmr_pkg::MASK_D8);
         tmr_pkg::CS_D64:
            tick = &(st_r.pre | ~tmr_pkg::MASK_D64);
         tmr_pkg::CS_D256:
            tick = &(st_r.pre | ~tmr_pkg::MASK_D256);
         tmr_pkg::CS_D1K:
            tick = &(st_r.pre | ~tmr_pkg::MASK_D1K);
         // Pin is sampled whatever its port direction
         tmr_pkg::CS_EXTF:
            tick = st_r.extPrev & ~st_r.extStable;
         tmr_pkg::CS_EXTR:
            tick = ~st_r.extPrev & st_r.extStable;
      endcase
   end

   // Capture source and edge detect
   always_comb begin
      // Filtered path lags the direct path by the window
      if (st_r.ctrlB[tmr_pkg::NOISE_BIT]) begin
         capLevel = st_r.capFilt;
      end else begin
         capLevel = st_r.capStable;
      end
      if (capFromComp) begin
         capLevel = compOut;
      end
      if (st_r.ctrlB[tmr_pkg::EDGE_BIT]) begin
         capEdge = capLevel & ~st_r.capPrev;
      end else begin
         capEdge = ~capLevel & st_r.capPrev;
      end
      // Capture pin is cut off while it sets top
      if (capIsTop) begin
         capEdge = 1'b0;
      end
   end

   // Compare and bus strobes
   always_comb begin
      // A counter write masks the following match
      matchA = tick && !st_r.block &&
               (st_r.cnt == st_r.cmpA);
      matchB = tick && !st_r.block &&
               (st_r.cnt == st_r.cmpB);
      wrCnt  = bus.wr && (bus.addr == tmr_pkg::ADDR_CNT_L);
      forceA = bus.wr && (bus.addr == tmr_pkg::ADDR_CTRL_C) &&
               bus.wdata[tmr_pkg::FORCE_A_BIT] && nonPwm;
      forceB = bus.wr && (bus.addr == tmr_pkg::ADDR_CTRL_C) &&
               bus.wdata[tmr_pkg::FORCE_B_BIT] && nonPwm;
   end

   // Flag set and clear terms
   always_comb begin
      // Same bit order as the clear vector below
      flagSet = {capEdge, matchB, matchA,
                 tick && !wrCnt && (st_r.cnt == top)};
      flagClr = 4'h0;
      if (bus.wr && (bus.addr == tmr_pkg::ADDR_FLAGS)) begin
         flagClr = {bus.wdata[tmr_pkg::FLAG_CAP],
                    bus.wdata[tmr_pkg::FLAG_CMPB],
                    bus.wdata[tmr_pkg::FLAG_CMPA],
                    bus.wdata[tmr_pkg::FLAG_OVF]};
      end
   end

   // Next state
   always_comb begin
      st_nxt = st_r;

      // Pin synchronisers, first stage feeds second only
      st_nxt.capSync = {st_r.capSync[1:0], capturePin};
      st_nxt.extSync = {st_r.extSync[1:0], extCountPin};
      if (st_r.capSync[1] == st_r.capSync[2]) begin
         st_nxt.capStable = st_r.capSync[2];
      end
      if (st_r.extSync[1] == st_r.extSync[2]) begin
         st_nxt.extStable = st_r.extSync[2];
      end
      st_nxt.extPrev = st_r.extStable;
      st_nxt.capPrev = capLevel;

      // Noise filter: output follows four equal samples
      st_nxt.capHist = {st_r.capHist[tmr_pkg::FILT_LEN-2:0],
                        st_r.capSync[2]};
      if (&st_r.capHist) begin
         st_nxt.capFilt = 1'b1;
      end else if (~|st_r.capHist) begin
         st_nxt.capFilt = 1'b0;
      end

      // Free running prescaler
      st_nxt.pre = st_r.pre + 10'h001;

      // Counter sequence and match blocking
      if (tick) begin
         st_nxt.block = 1'b0;
         if (st_r.cnt == top) begin
            st_nxt.cnt = tmr_pkg::WORD_RST;
         end else begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
         end
      end

      // Compare actions on the waveform outputs
      if (matchA && nonPwm) begin
         st_nxt.waveA = waveAct(comA, st_r.waveA);
      end
      if (matchB && nonPwm) begin
         st_nxt.waveB = waveAct(comB, st_r.waveB);
      end
      // Forced strobe: output only, counter untouched
      if (forceA) begin
         st_nxt.waveA = waveAct(comA, st_r.waveA);
      end
      if (forceB) begin
         st_nxt.waveB = waveAct(comB, st_r.waveB);
      end
      // Match on top in clear-on-match mode A also clears via match
      if (ctcA && matchA) begin
         st_nxt.cnt = tmr_pkg::WORD_RST;
      end

      // Event flags, a set beats a clear
      st_nxt.flags = (st_r.flags & ~flagClr) | flagSet;

      // Read data stands one cycle only
      st_nxt.rdata = 8'h00;

      // Register writes
      if (bus.wr) begin
         unique case (bus.addr)
            tmr_pkg::ADDR_CTRL_A: st_nxt.ctrlA = bus.wdata;
            tmr_pkg::ADDR_CTRL_B:
               st_nxt.ctrlB = bus.wdata &
                              tmr_pkg::CTRL_B_MASK;
            // High bytes go to the shared latch
            tmr_pkg::ADDR_CNT_H, tmr_pkg::ADDR_CAP_H,
            tmr_pkg::ADDR_CMPA_H, tmr_pkg::ADDR_CMPB_H:
               st_nxt.temp = bus.wdata;
            // Low byte commits the whole word
            tmr_pkg::ADDR_CNT_L: begin
               st_nxt.cnt   = {st_r.temp, bus.wdata};
               st_nxt.block = 1'b1;
            end
            tmr_pkg::ADDR_CAP_L:
               st_nxt.cap  = {st_r.temp, bus.wdata};
            tmr_pkg::ADDR_CMPA_L:
               st_nxt.cmpA = {st_r.temp, bus.wdata};
            tmr_pkg::ADDR_CMPB_L:
               st_nxt.cmpB = {st_r.temp, bus.wdata};
            // Strobe-only, flag and unmapped writes store nothing
            default: st_nxt.rdata = 8'h00;
         endcase
      end

      // A capture beats a software write of the same word
      if (capEdge) begin
         st_nxt.cap = st_r.cnt;
      end

      // Register reads
      if (bus.rd) begin
         unique case (bus.addr)
            tmr_pkg::ADDR_CTRL_A: st_nxt.rdata = st_r.ctrlA;
            tmr_pkg::ADDR_CTRL_B: st_nxt.rdata = st_r.ctrlB;
            // Force bits are strobes
            tmr_pkg::ADDR_CTRL_C: st_nxt.rdata = 8'h00;
            tmr_pkg::ADDR_FLAGS:
               st_nxt.rdata = {2'h0, st_r.flags[3], 2'h0,
                               st_r.flags[2:0]};
            // Low byte read latches the matching high byte
            tmr_pkg::ADDR_CNT_L: begin
               st_nxt.rdata = st_r.cnt[7:0];
               st_nxt.temp  = st_r.cnt[15:8];
            end
            tmr_pkg::ADDR_CAP_L: begin
               st_nxt.rdata = st_r.cap[7:0];
               st_nxt.temp  = st_r.cap[15:8];
            end
            tmr_pkg::ADDR_CMPA_L: begin
               st_nxt.rdata = st_r.cmpA[7:0];
               st_nxt.temp  = st_r.cmpA[15:8];
            end
            tmr_pkg::ADDR_CMPB_L: begin
               st_nxt.rdata = st_r.cmpB[7:0];
               st_nxt.temp  = st_r.cmpB[15:8];
            end
            // High byte reads return the shared latch
            tmr_pkg::ADDR_CNT_H, tmr_pkg::ADDR_CAP_H,
            tmr_pkg::ADDR_CMPA_H, tmr_pkg::ADDR_CMPB_H:
               st_nxt.rdata = st_r.temp;
            default: st_nxt.rdata = 8'h00;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs from the state register
   assign rdata      = st_r.rdata;
   assign waveOutA   = st_r.waveA;
   assign waveOutB   = st_r.waveB;
   assign waveEnA    = (comA != tmr_pkg::COM_OFF);
   assign waveEnB    = (comB != tmr_pkg::COM_OFF);
   assign eventFlags = st_r.flags;

endmodule : tmr_unit

/* tmr_pin_model.sv */
`timescale 1ns/1ps

// Far side of the timer: capture pin, count pin, comparator
module tmr_pin_model (
   // Clock
   input  wire logic clk,
   // Pins toward the timer, always driven
   output logic      capturePin,
   output logic      extCountPin,
   output logic      compOut
);

   // Quiet pins from time zero
   initial {capturePin, extCountPin, compOut} = 3'h0;

   // Hold the capture pin at a level for n cycles
   task automatic cap(input logic lvl, input int n);
      capturePin <= lvl;
      repeat (n) @(posedge clk);
   endtask : cap

   // Hold the comparator level for n cycles
   task automatic cmp(input logic lvl, input int n);
      compOut <= lvl;
      repeat (n) @(posedge clk);
   endtask : cmp

   // Whole pulses, long enough for the synchroniser
   task automatic pulses(input int n);
      repeat (n) begin
         extCountPin <= 1'b1;
         repeat (4) @(posedge clk);
         extCountPin <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask : pulses

endmodule : tmr_pin_model

/* tmr_unit_monitor.sv */
`timescale 1ns/1ps

// Port-level checker for one timer unit
module tmr_unit_monitor (
   // Clock and reset
   input wire logic                 clk,
   input wire logic                 sys_rst,
   // Register bus
   input wire tmr_pkg::tmr_bus_type bus,
   input wire logic [7:0]           rdata,
   // Pins
   input wire logic                 capturePin,
   input wire logic                 extCountPin,
   input wire logic                 compOut,
   input wire logic                 capFromComp,
   // Waveform outputs
   input wire logic                 waveOutA,
   input wire logic                 waveEnA,
   input wire logic                 waveOutB,
   input wire logic                 waveEnB,
   // Event flags
   input wire logic [3:0]           eventFlags
);

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   logic [7:0] ctrlA_r;  // Shadow of control A
   logic [7:0] ctrlB_r;  // Shadow of control B
   logic [3:0] mode;     // Waveform mode
   logic       nonPwm;   // Normal or clear-on-match
   logic       stopped;  // No clock source
   logic       wrC;      // Write to control C
   logic       expA;     // Output A after a forced match

   // Follow control writes
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrlA_r <= 8'h00;
         ctrlB_r <= 8'h00;
      end else if (bus.wr && bus.addr == tmr_pkg::ADDR_CTRL_A) begin
         ctrlA_r <= bus.wdata;
      end else if (bus.wr && bus.addr == tmr_pkg::ADDR_CTRL_B) begin
         ctrlB_r <= bus.wdata;
      end
   end

   assign mode = {ctrlB_r[4:3], ctrlA_r[1:0]};
   assign nonPwm = mode == 4'h0 || mode == 4'h4 || mode == 4'hC;
   assign stopped = ctrlB_r[2:0] == tmr_pkg::CS_STOP;
   assign wrC = bus.wr && bus.addr == tmr_pkg::ADDR_CTRL_C;

   // Output action chosen by channel A mode
   always_comb begin
      case (ctrlA_r[7:6])
         tmr_pkg::COM_SET:   expA = 1'b1;
         tmr_pkg::COM_CLEAR: expA = 1'b0;
         default:            expA = ~waveOutA;
      endcase
   end

   // Forced match on A while connected and idle
   sequence s_forceA;
      wrC && bus.wdata[7] && nonPwm && stopped && waveEnA;
   endsequence

   a_force_reads_zero: assert property (
      $past(bus.rd && bus.addr == tmr_pkg::ADDR_CTRL_C) |-> rdata == 8'h00)
      else $error("control C read not zero");
   a_ctrl_b_image: assert property (
      $past(bus.rd && bus.addr == tmr_pkg::ADDR_CTRL_B)
      |-> rdata == (ctrlB_r & tmr_pkg::CTRL_B_MASK))
      else $error("control B read wrong");
   a_enable_follow: assert property (
      waveEnA == (ctrlA_r[7:6] != tmr_pkg::COM_OFF)
      && waveEnB == (ctrlA_r[5:4] != tmr_pkg::COM_OFF))
      else $error("output enable wrong");
   a_force_action: assert property (
      s_forceA |=> waveOutA == $past(expA))
      else $error("forced match action wrong");
   a_pwm_no_force: assert property (
      wrC && bus.wdata[7] && !nonPwm |=> $stable(waveOutA))
      else $error("force acted in PWM mode");
   a_force_no_flag: assert property (
      wrC && stopped && eventFlags[2:1] == 2'b00
      |=> eventFlags[2:1] == 2'b00)
      else $error("force set a flag");
   a_stop_no_tick: assert property (
      stopped && eventFlags[2:0] == 3'b000 |=> eventFlags[2:0] == 3'b000)
      else $error("stopped timer raised a flag");
   a_cap_top_off: assert property (
      mode == 4'hC && stopped && !eventFlags[3] |=> !eventFlags[3])
      else $error("capture ran with capture as top");
   a_cap_sticky: assert property (
      eventFlags[3] && !(bus.wr && bus.addr == tmr_pkg::ADDR_FLAGS
      && bus.wdata[5]) |=> eventFlags[3])
      else $error("capture flag lost");

endmodule : tmr_unit_monitor

/* tmr_unit_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
   mismatches++; $display("unexpected %s exp %h got %h", n, e, g); end end

module tmr_unit_tb;

   // Bench signals
   logic                 clk = 1'b0;
   logic                 sys_rst = 1'b1;
   tmr_pkg::tmr_bus_type bus = '0;
   logic [7:0]           rdata;
   logic                 capturePin, extCountPin, compOut;
   logic                 capFromComp = 1'b0;
   logic                 waveOutA, waveEnA, waveOutB, waveEnB;
   logic [3:0]           eventFlags;
   int                   mismatches = 0;
   int                   check_count = 0;

   always #10 clk = ~clk;

   tmr_unit i_dut (.clk, .sys_rst, .bus, .rdata, .capturePin,
      .extCountPin, .compOut, .capFromComp, .waveOutA, .waveEnA,
      .waveOutB, .waveEnB, .eventFlags);
   tmr_pin_model i_pins (.clk, .capturePin, .extCountPin, .compOut);

   // One write, then a quiet cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
      @(posedge clk);
   endtask : wr

   // One read, data taken in the following cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      @(negedge clk);
      d = rdata;
      @(posedge clk);
   endtask : rd

   // Word access through the shared high byte
   task automatic wr16(input logic [7:0] a, input logic [15:0] v);
      wr(a + 8'h01, v[15:8]);
      wr(a, v[7:0]);
   endtask : wr16

   task automatic rd16(input logic [7:0] a, output logic [15:0] v);
      rd(a, v[7:0]);
      rd(a + 8'h01, v[15:8]);
   endtask : rd16

   // Every byte clear after reset, unmapped reads zero
   task automatic t_reset;
      logic [7:0] d;
      for (int i = 0; i < 13; i++) begin
         rd((i < 12) ? 8'(8'h80 + i) : 8'h90, d);
         `CHK("reset byte", 8'h00, d)
      end
      $display("reset test done");
   endtask : t_reset

   // Control images, word access, latch sharing
   task automatic t_regs;
      logic [7:0]  d;
      logic [15:0] v;
      wr(tmr_pkg::ADDR_CTRL_B, 8'hD8);
      rd(tmr_pkg::ADDR_CTRL_B, d);
      `CHK("ctrl b", 8'hD8, d)
      wr(tmr_pkg::ADDR_CTRL_B, 8'h00);
      wr(tmr_pkg::ADDR_CTRL_C, 8'hC0);
      rd(tmr_pkg::ADDR_CTRL_C, d);
      `CHK("ctrl c", 8'h00, d)
      wr16(tmr_pkg::ADDR_CMPB_L, 16'hABCD);
      rd16(tmr_pkg::ADDR_CMPB_L, v);
      `CHK("compare b", 16'hABCD, v)
      wr16(tmr_pkg::ADDR_CNT_L, 16'h9ABC);
      rd16(tmr_pkg::ADDR_CNT_L, v);
      `CHK("count", 16'h9ABC, v)
      wr(tmr_pkg::ADDR_CMPA_H, 8'h56);
      rd(tmr_pkg::ADDR_CNT_L, d);
      wr(tmr_pkg::ADDR_CMPA_L, 8'h78);
      rd16(tmr_pkg::ADDR_CMPA_L, v);
      `CHK("shared latch", 16'h9A78, v)
      $display("register test done");
   endtask : t_regs

   // Each clock source: stop, prescales, count pin edges
   task automatic t_clock;
      int          dv [6] = '{0, 1, 8, 64, 256, 1024};
      int          n;
      logic [15:0] v;
      for (int c = 0; c < 8; c++) begin
         wr16(tmr_pkg::ADDR_CNT_L, 16'h0000);
         wr(tmr_pkg::ADDR_CTRL_B, 8'(c));
         i_pins.pulses((c < 6) ? 0 : c - 3);
         repeat ((c < 6) ? 2048 : 8) @(posedge clk);
         wr(tmr_pkg::ADDR_CTRL_B, 8'h00);
         rd16(tmr_pkg::ADDR_CNT_L, v);
         n = (c >= 6) ? c - 3 : (c == 0) ? 0 : 2050 / dv[c];
         if (c >= 6 || c == 0) `CHK("ticks", 16'(n), v)
         else `CHK("prescale", 1'b1, v >= n - 1 && v <= n + 1)
      end
      $display("clock test done");
   endtask : t_clock

   // Match, blocked match, clear-on-match and overflow
   task automatic t_compare;
      logic [15:0] v;
      wr16(tmr_pkg::ADDR_CMPA_L, 16'h0010);
      wr16(tmr_pkg::ADDR_CMPB_L, 16'h0008);
      wr16(tmr_pkg::ADDR_CNT_L, 16'h0000);
      wr(tmr_pkg::ADDR_CTRL_A, 8'h40);
      wr(tmr_pkg::ADDR_FLAGS, 8'h27);
      wr(tmr_pkg::ADDR_CTRL_B, 8'h01);
      repeat (40) @(posedge clk);
      wr(tmr_pkg::ADDR_CTRL_B, 8'h00);
      `CHK("match flags", 2'b11, eventFlags[2:1])
      `CHK("toggled out", 1'b1, waveOutA)
      wr(tmr_pkg::ADDR_FLAGS, 8'h27);
      wr16(tmr_pkg::ADDR_CNT_L, 16'h0010);
      wr(tmr_pkg::ADDR_CTRL_B, 8'h01);
      repeat (10) @(posedge clk);
      wr(tmr_pkg::ADDR_CTRL_B, 8'h00);
      `CHK("blocked match", 1'b0, eventFlags[1])
      wr16(tmr_pkg::ADDR_CNT_L, 16'h0000);
      wr(tmr_pkg::ADDR_CTRL_B, 8'h09);
      repeat (100) @(posedge clk);
      wr(tmr_pkg::ADDR_CTRL_B, 8'h08);
      rd16(tmr_pkg::ADDR_CNT_L, v);
      `CHK("top from a", 1'b1, v <= 16'h0010)
      wr16(tmr_pkg::ADDR_CNT_L, 16'hFFF0);
      wr(tmr_pkg::ADDR_FLAGS, 8'h27);
      wr(tmr_pkg::ADDR_CTRL_B, 8'h01);
      repeat (40) @(posedge clk);
      wr(tmr_pkg::ADDR_CTRL_B, 8'h00);
      rd16(tmr_pkg::ADDR_CNT_L, v);
      `CHK("overflow", 1'b1, eventFlags[0] && v < 16'h0030)
      $display("compare test done");
   endtask : t_compare

   // Forced matches in clear, set and toggle modes, then PWM and CLEAR_ON_MATCH_MODE
   task automatic t_force;
      logic [1:0]  com [3] = '{2'h2, 2'h3, 2'h1};
      logic        ex [3] = '{1'b0, 1'b1, 1'b0};
      logic [15:0] v;
      wr(tmr_pkg::ADDR_FLAGS, 8'h27);
      for (int i = 0; i < 3; i++) begin
         wr(tmr_pkg::ADDR_CTRL_A, {com[i], com[i], 4'h0});
         wr(tmr_pkg::ADDR_CTRL_C, 8'hC0);
         `CHK("forced a", ex[i], waveOutA)
         `CHK("forced b", ex[i], waveOutB)
      end
      `CHK("no flag", 2'b00, eventFlags[2:1])
      wr(tmr_pkg::ADDR_CTRL_B, 8'h08);
      wr(tmr_pkg::ADDR_CTRL_A, 8'hF1);
      wr(tmr_pkg::ADDR_CTRL_C, 8'hC0);
      `CHK("pwm force", 1'b0, waveOutA)
      wr(tmr_pkg::ADDR_CTRL_A, 8'hC0);
      wr16(tmr_pkg::ADDR_CNT_L, 16'h0010);
      wr(tmr_pkg::ADDR_CTRL_C, 8'h80);
      rd16(tmr_pkg::ADDR_CNT_L, v);
      `CHK("ctc kept", 16'h0010, v)
      wr(tmr_pkg::ADDR_CTRL_A, 8'h00);
      `CHK("disconnected", 1'b0, waveEnA)
      $display("force test done");
   endtask : t_force

   // Edges, filter, capture-as-top and comparator source
   task automatic t_capture;
      logic [15:0] v;
      wr(tmr_pkg::ADDR_CTRL_B, 8'h40);
      wr16(tmr_pkg::ADDR_CNT_L, 16'h1234);
      wr(tmr_pkg::ADDR_FLAGS, 8'h20);
      i_pins.cap(1'b1, 7);
      `CHK("rising", 1'b1, eventFlags[3])
      rd16(tmr_pkg::ADDR_CAP_L, v);
      `CHK("captured", 16'h1234, v)
      wr(tmr_pkg::ADDR_FLAGS, 8'h20);
      wr16(tmr_pkg::ADDR_CNT_L, 16'h2345);
      i_pins.cap(1'b0, 7);
      `CHK("fall ignored", 1'b0, eventFlags[3])
      wr(tmr_pkg::ADDR_CTRL_B, 8'h00);
      i_pins.cap(1'b1, 7);
      `CHK("rise ignored", 1'b0, eventFlags[3])
      i_pins.cap(1'b0, 7);
      rd16(tmr_pkg::ADDR_CAP_L, v);
      `CHK("falling", 1'b1, eventFlags[3] && v == 16'h2345)
      wr(tmr_pkg::ADDR_FLAGS, 8'h20);
      wr(tmr_pkg::ADDR_CTRL_B, 8'hC0);
      i_pins.cap(1'b1, 3);
      i_pins.cap(1'b0, 10);
      `CHK("short pulse", 1'b0, eventFlags[3])
      i_pins.cap(1'b1, 5);
      // Four cycles behind the direct path, seen mid-cycle
      repeat (3) @(posedge clk);
      @(negedge clk);
      `CHK("filter lag", 1'b0, eventFlags[3])
      @(negedge clk);
      `CHK("filtered", 1'b1, eventFlags[3])
      @(posedge clk);
      wr(tmr_pkg::ADDR_FLAGS, 8'h20);
      wr(tmr_pkg::ADDR_CTRL_B, 8'h58);
      i_pins.cap(1'b0, 4);
      i_pins.cap(1'b1, 8);
      `CHK("top mode", 1'b0, eventFlags[3])
      wr(tmr_pkg::ADDR_CTRL_B, 8'h40);
      capFromComp <= 1'b1;
      wr(tmr_pkg::ADDR_FLAGS, 8'h20);
      i_pins.cmp(1'b1, 8);
      `CHK("comparator", 1'b1, eventFlags[3])
      $display("capture test done");
   endtask : t_capture

   // Counts, verdict and end of run
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop

   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_regs;
      t_clock;
      t_compare;
      t_force;
      t_capture;
      report_and_stop;
   end

   // Watchdog, about four times the expected run
   initial begin
      #1_000_000;
      mismatches++;
      report_and_stop;
   end

endmodule : tmr_unit_tb

bind tmr_unit tmr_unit_monitor i_mon (.clk, .sys_rst, .bus, .rdata,
   .capturePin, .extCountPin, .compOut, .capFromComp, .waveOutA,
   .waveEnA, .waveOutB, .waveEnB, .eventFlags);
